// ==== rtl/hbg_device.sv ====
`timescale 1ns/1ns
module hbg_device
    import hbg_pkg::*;
(
    input  wire logic        clk_in,              // 125 MHz clock
    input  wire logic        rst_in,              // Async reset, active high
    hbg_if.device            bus,                 // Board side
    input  wire logic        acc_io_rd_in,        // Host I/O read in progress
    input  wire logic        acc_io_wr_in,        // Host I/O write in progress
    input  wire logic        acc_mem_rd_in,       // Host memory read in progress
    input  wire logic        acc_mem_wr_in,       // Host memory write in progress
    input  wire logic [15:0] acc_addr_in,         // Host I/O address
    input  wire logic        acc_hi_byte_in,      // Access includes upper byte
    input  wire logic        rom_decode_in,       // Address hits the BIOS ROM
    input  wire logic        wide_in,             // Access is 16 bits wide
    output logic             bus_arch_strap_out,  // Latched personality
    output logic             strap_valid_out,     // Strap captured
    output logic [15:0]      host_word_out,       // Registered combined input
    output logic [4:0]       host_addr_high_out,  // Registered high address
    output logic             mem_cycle_en_out     // Registered cycle qualifier
);
    // ********************************************
    // Glue inputs
    // ********************************************
    logic [21:0] held;
    logic [21:0] next_held;

    // Same-clock glue outputs need no synchroniser
    always_comb begin
        next_held = {bus.combined_host_input, bus.host_addr_high, bus.memory_cycle_enable};
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            held <= 22'h0;
        end else begin
            held <= next_held;
        end
    end

    // ********************************************
    // Strap capture after reset release
    // ********************************************
    hbg_strap_state_t state;
    hbg_strap_state_t next_state;
    logic [2:0]       settle;
    logic [2:0]       next_settle;
    logic             strap;
    logic             next_strap;

    // Wait out the glue pin path, capture once, then hold
    always_comb begin
        next_state  = state;
        next_settle = settle;
        next_strap  = strap;
        case (state)
            ST_WAIT: begin
                next_settle = settle + 3'h1;
                if (settle == STRAP_SETTLE_CYCLES - 3'h1) begin
                    next_strap = bus.mem_data_line_2;
                    next_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                next_strap = strap;
            end
            default: begin
                next_state = ST_WAIT;
            end
        endcase
    end

    // No port reaches the strap
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state  <= ST_WAIT;
            settle <= SETTLE_RESET;
            strap  <= STRAP_RESET;
        end else begin
            state  <= next_state;
            settle <= next_settle;
            strap  <= next_strap;
        end
    end

    // ********************************************
    // Buffer, ROM and palette strobes
    // ********************************************
    logic is_isa;
    logic enabled;
    logic acc_io;
    logic acc_any;
    logic setup_hit;
    logic pal_hit;
    logic next_high_n;
    logic next_low_n;
    logic next_rom_n;
    logic next_wide_n;
    logic next_pal_wr_n;
    logic next_pal_rd_n;
    logic high_n;
    logic low_n;
    logic rom_n;
    logic wide_n;
    logic pal_wr_n;
    logic pal_rd_n;

    // Decode, qualified by the personality and cycle enable
    always_comb begin
        is_isa    = (strap == STRAP_ISA);
        enabled   = (state == ST_HOLD) && (is_isa || bus.memory_cycle_enable);
        acc_io    = acc_io_rd_in || acc_io_wr_in;
        acc_any   = enabled && (acc_io || acc_mem_rd_in || acc_mem_wr_in);
        setup_hit = (state == ST_HOLD) && is_isa && acc_io
                    && (acc_addr_in[15:14] == SETUP_PORT_TOP)
                    && (acc_addr_in[11:0] == SETUP_PORT_LOW);
        pal_hit   = enabled && acc_io && (acc_addr_in >= PAL_PORT_FIRST)
                    && (acc_addr_in <= PAL_PORT_LAST);
        next_low_n = !acc_any;
        if (is_isa) begin
            next_high_n = !acc_any;
        end else begin
            next_high_n = !(acc_any && acc_hi_byte_in);
        end
        next_rom_n    = !((enabled && rom_decode_in && acc_mem_rd_in) || setup_hit);
        next_wide_n   = !(acc_any && wide_in);
        next_pal_wr_n = !(pal_hit && acc_io_wr_in);
        next_pal_rd_n = !(pal_hit && acc_io_rd_in);
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            high_n   <= 1'b1;
            low_n    <= 1'b1;
            rom_n    <= 1'b1;
            wide_n   <= 1'b1;
            pal_wr_n <= 1'b1;
            pal_rd_n <= 1'b1;
        end else begin
            high_n   <= next_high_n;
            low_n    <= next_low_n;
            rom_n    <= next_rom_n;
            wide_n   <= next_wide_n;
            pal_wr_n <= next_pal_wr_n;
            pal_rd_n <= next_pal_rd_n;
        end
    end

    // Outputs straight from flops
    assign bus.high_byte_buf_en_n     = high_n;
    assign bus.low_byte_buf_en_n      = low_n;
    assign bus.bios_rom_select_n      = rom_n;
    assign bus.wide_data_select_n     = wide_n;
    assign bus.palette_write_strobe_n = pal_wr_n;
    assign bus.palette_read_strobe_n  = pal_rd_n;
    assign bus_arch_strap_out         = strap;
    assign strap_valid_out            = state[1];
    assign host_word_out              = held[21:6];
    assign host_addr_high_out         = held[5:1];
    assign mem_cycle_en_out           = held[0];
endmodule : hbg_device

// ==== rtl/hbg_glue.sv ====
`timescale 1ns/1ns
// What this block does
// - Device latches strap from memory data line 2
// - Strap 0 second bus, 1 ISA
// - Strap reachable through no I/O port
// - Second bus: high enable gates upper byte
// - Second bus byte enables and palette strobes
// - Upper buffer gate for 8-bit BIOS board
// - Low ROM enable on even ROM reads
// - High ROM enable for wide or odd reads
// - Cross buffer passes odd narrow ROM bytes
// - Upper buffer gate for 16-bit BIOS board
// - Cycle enable for low memory or I/O
// - Mux data/address, latch address bits 19:15
// - Monitor sense and D15 on top line
// - Optional ROM page address lines 12:14
// - ROM select strobes on setup port access, ISA strap only
// - Subsystem enable set at power on
module hbg_glue
    import hbg_pkg::*;
(
    input  wire logic        clk_in,                      // 125 MHz clock
    input  wire logic        rst_in,                      // Async reset, active high
    hbg_if.glue              bus,                         // Device side
    input  wire logic        strap_pullup_in,             // Board resistor choice
    input  wire logic        smemr_n_in,                  // System memory read
    input  wire logic        smemw_n_in,                  // System memory write
    input  wire logic        sbhe_n_in,                   // System byte high enable
    input  wire logic        sa0_in,                      // System address bit 0
    input  wire logic        siow_n_in,                   // System I/O write
    input  wire logic [15:0] sio_addr_in,                 // System I/O address
    input  wire logic [15:0] sdata_in,                    // System data bus
    input  wire logic [8:0]  saddr_top_in,                // Address bits 23:15
    input  wire logic        m_io_in,                     // High memory, low I/O
    input  wire logic        made24_in,                   // Address extension bit
    input  wire logic        addr_latch_in,               // Latch high address while high
    input  wire logic        data_phase_in,               // High data, low address
    input  wire logic        monitor_sense_in,            // Monitor sense buffer
    input  wire logic        rom_is_wide_n_in,            // Low for 16-bit ROM
    output logic             upper_buf_gate_n_out,        // 8-bit BIOS upper gate
    output logic             rom_low_oe_n_out,            // Even ROM output enable
    output logic             rom_high_oe_n_out,           // Odd ROM output enable
    output logic             rom_cross_buf_gate_n_out,    // ROM cross buffer gate
    output logic             upper_buf_gate_wide_rom_n_out, // 16-bit BIOS upper gate
    output logic [2:0]       rom_page_addr_out,           // ROM address lines 14:12
    output logic             subsys_enable_out            // Subsystem enable bit
);
    // ********************************************
    // Pin synchronisers
    // ********************************************
    localparam int SW = 53;

    logic [SW-1:0] sync_a;
    logic [SW-1:0] sync_b;
    logic [SW-1:0] next_sync_a;
    logic [SW-1:0] next_sync_b;

    // Two stages for every external input pin
    always_comb begin
        next_sync_a = {strap_pullup_in, smemr_n_in, smemw_n_in, sbhe_n_in, sa0_in,
                       siow_n_in, sio_addr_in, sdata_in, saddr_top_in, m_io_in,
                       made24_in, addr_latch_in, data_phase_in, monitor_sense_in,
                       rom_is_wide_n_in};
        next_sync_b = sync_a;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sync_a <= {SW{1'b1}};
            sync_b <= {SW{1'b1}};
        end else begin
            sync_a <= next_sync_a;
            sync_b <= next_sync_b;
        end
    end

    // ********************************************
    // Synchronised names
    // ********************************************
    logic        s_strap;
    logic        s_smemr_n;
    logic        s_smemw_n;
    logic        s_sbhe_n;
    logic        s_sa0;
    logic        s_siow_n;
    logic [15:0] s_io_addr;
    logic [15:0] s_data;
    logic [8:0]  s_top;
    logic        s_m_io;
    logic        s_made24;
    logic        s_latch;
    logic        s_phase;
    logic        s_sense;
    logic        s_rom_wide_n;
    logic        s_low_n;
    logic        s_rom_n;
    logic        s_wide_n;

    // Split the second stage; device strobes share the clock
    always_comb begin
        {s_strap, s_smemr_n, s_smemw_n, s_sbhe_n, s_sa0, s_siow_n, s_io_addr, s_data,
         s_top, s_m_io, s_made24, s_latch, s_phase, s_sense, s_rom_wide_n} = sync_b;
        s_low_n  = bus.low_byte_buf_en_n;
        s_rom_n  = bus.bios_rom_select_n;
        s_wide_n = bus.wide_data_select_n;
    end

    // ********************************************
    // Buffer and ROM gating
    // ********************************************
    logic next_upper_n;
    logic next_rom_lo_n;
    logic next_rom_hi_n;
    logic next_cross_n;
    logic next_upper_wide_n;
    logic upper_n;
    logic rom_lo_n;
    logic rom_hi_n;
    logic cross_n;
    logic upper_wide_n;

    // Board equations on synchronised pins
    always_comb begin
        next_upper_n = !(!s_low_n && s_rom_n && !s_sbhe_n && !s_wide_n
                         && (!s_smemw_n || !s_smemr_n));
        next_rom_lo_n = !(!s_rom_n && !s_smemr_n && !s_sa0);
        next_rom_hi_n = !(!s_rom_n && !s_smemr_n
                          && ((!s_sbhe_n && !s_rom_wide_n)
                              || (s_sa0 && s_rom_wide_n)));
        next_cross_n = !(!s_rom_n && s_sa0 && !s_smemr_n && s_rom_wide_n);
        next_upper_wide_n = !(!s_sbhe_n
                              && ((!s_low_n && !s_smemw_n && !s_wide_n)
                                  || (!s_rom_n && !s_smemr_n && !s_rom_wide_n)
                                  || (!s_low_n && !s_smemr_n && !s_wide_n
                                      && s_rom_n)));
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            upper_n      <= 1'b1;
            rom_lo_n     <= 1'b1;
            rom_hi_n     <= 1'b1;
            cross_n      <= 1'b1;
            upper_wide_n <= 1'b1;
        end else begin
            upper_n      <= next_upper_n;
            rom_lo_n     <= next_rom_lo_n;
            rom_hi_n     <= next_rom_hi_n;
            cross_n      <= next_cross_n;
            upper_wide_n <= next_upper_wide_n;
        end
    end

    // ********************************************
    // Ports, latches and combined input
    // ********************************************
    logic        subsys;
    logic        next_subsys;
    logic [2:0]  page;
    logic [2:0]  next_page;
    logic [4:0]  addr_high;
    logic [4:0]  next_addr_high;
    logic [15:0] word;
    logic [15:0] next_word;
    logic        mem_en;
    logic        next_mem_en;
    logic        strap_pin;
    logic        next_strap_pin;

    // Subsystem port, page map, address latch and multiplexer
    always_comb begin
        next_subsys = subsys;
        if (!s_siow_n && (s_io_addr == SUBSYS_PORT)) begin
            next_subsys = s_data[0];
        end
        next_page = page;
        if (!s_siow_n && !s_rom_n) begin
            next_page = s_data[2:0];
        end
        next_addr_high = addr_high;
        if (s_latch) begin
            next_addr_high = s_top[4:0];
        end
        if (s_phase) begin
            next_word = s_data;
        end else begin
            next_word = {s_sense, s_io_addr[14:0]};
        end
        next_mem_en = subsys && ((s_m_io && (s_top[8:5] == 4'h0) && s_made24)
                                 || !s_m_io);
        next_strap_pin = s_strap;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            subsys    <= SUBSYS_RESET;
            page      <= PAGE_RESET;
            addr_high <= ADDR_HIGH_RESET;
            word      <= WORD_RESET;
            mem_en    <= 1'b0;
            strap_pin <= STRAP_RESET;
        end else begin
            subsys    <= next_subsys;
            page      <= next_page;
            addr_high <= next_addr_high;
            word      <= next_word;
            mem_en    <= next_mem_en;
            strap_pin <= next_strap_pin;
        end
    end

    // Outputs straight from flops
    assign bus.combined_host_input     = word;
    assign bus.host_addr_high          = addr_high;
    assign bus.memory_cycle_enable     = mem_en;
    assign bus.mem_data_line_2         = strap_pin;
    assign upper_buf_gate_n_out          = upper_n;
    assign rom_low_oe_n_out              = rom_lo_n;
    assign rom_high_oe_n_out             = rom_hi_n;
    assign rom_cross_buf_gate_n_out      = cross_n;
    assign upper_buf_gate_wide_rom_n_out = upper_wide_n;
    assign rom_page_addr_out             = page;
    assign subsys_enable_out             = subsys;
endmodule : hbg_glue

// ==== rtl/hbg_if.sv ====
`timescale 1ns/1ns
interface hbg_if;
    // ********************************************
    // Board glue to device
    // ********************************************
    logic [15:0] combined_host_input;        // Multiplexed data and address
    logic [4:0]  host_addr_high;             // Latched address bits 19:15
    logic        memory_cycle_enable;        // Second-bus cycle qualifier
    logic        mem_data_line_2;            // Strap level from board resistor

    // ********************************************
    // Device to board glue
    // ********************************************
    logic        high_byte_buf_en_n;
    logic        low_byte_buf_en_n;
    logic        bios_rom_select_n;
    logic        wide_data_select_n;
    logic        palette_write_strobe_n;
    logic        palette_read_strobe_n;

    modport device (
        input  combined_host_input, host_addr_high, memory_cycle_enable, mem_data_line_2,
        output high_byte_buf_en_n, low_byte_buf_en_n, bios_rom_select_n,
        output wide_data_select_n, palette_write_strobe_n, palette_read_strobe_n
    );

    modport glue (
        output combined_host_input, host_addr_high, memory_cycle_enable, mem_data_line_2,
        input  high_byte_buf_en_n, low_byte_buf_en_n, bios_rom_select_n,
        input  wide_data_select_n, palette_write_strobe_n, palette_read_strobe_n
    );
endinterface : hbg_if

// ==== rtl/hbg_pkg.sv ====
package hbg_pkg;
    // ********************************************
    // Strap and reset timing
    // ********************************************
    localparam logic       STRAP_ISA           = 1'b1;   // Pulled-up strap, ISA personality
    localparam logic       STRAP_ALT           = 1'b0;   // Second host-bus personality
    localparam logic       STRAP_RESET         = 1'b1;   // Strap value before capture
    localparam logic [2:0] STRAP_SETTLE_CYCLES = 3'h5;   // Edges after release before capture
    localparam logic [2:0] SETTLE_RESET        = 3'h0;

    // ********************************************
    // I/O port decode
    // ********************************************
    localparam logic [11:0] SETUP_PORT_LOW     = 12'h6e8; // Partially decoded setup port
    localparam logic [1:0]  SETUP_PORT_TOP     = 2'h1;    // Address bits 15:14 of the alias set
    localparam logic [15:0] PAL_PORT_FIRST     = 16'h03c6;
    localparam logic [15:0] PAL_PORT_LAST      = 16'h03c9;
    localparam logic [15:0] SUBSYS_PORT        = 16'h03c3;
    localparam logic        SUBSYS_RESET       = 1'b1;    // Decoding enabled after power on
    localparam logic [2:0]  PAGE_RESET         = 3'h0;
    localparam logic [4:0]  ADDR_HIGH_RESET    = 5'h00;
    localparam logic [15:0] WORD_RESET         = 16'h0000;

    // ********************************************
    // Strap capture states
    // ********************************************
    typedef enum logic [1:0] {
        ST_WAIT = 2'b01,
        ST_HOLD = 2'b10
    } hbg_strap_state_t;
endpackage : hbg_pkg

// ==== tb/hbg_properties.sv ====
`timescale 1ns/1ns
module hbg_properties (
    input  wire logic clk_in,                 // Clock
    input  wire logic rst_in,                 // Reset
    input  wire logic high_byte_buf_en_n,     // Upper lane
    input  wire logic low_byte_buf_en_n,      // Lower lane
    input  wire logic bios_rom_select_n,      // ROM select
    input  wire logic wide_data_select_n,     // Wide access
    input  wire logic palette_write_strobe_n, // Palette write
    input  wire logic palette_read_strobe_n,  // Palette read
    input  wire logic memory_cycle_enable     // Cycle qualifier
);
    // ****************************
    // Edges since reset release
    // ****************************
    logic [1:0] since_rst;
    logic [1:0] next_since_rst;

    // Saturating count, so early strobes can be caught
    always_comb begin
        next_since_rst = (since_rst == 2'h3) ? since_rst : since_rst + 2'h1;
    end
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            since_rst <= 2'h0;
        end else begin
            since_rst <= next_since_rst;
        end
    end

    // ****************************
    // Strobe relations
    // ****************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    chk_idle_enables: assert property (since_rst != 2'h3 |->
        high_byte_buf_en_n && low_byte_buf_en_n && wide_data_select_n && bios_rom_select_n)
        else $error("lane enable active before strap capture");
    chk_idle_palette: assert property (since_rst != 2'h3 |->
        palette_write_strobe_n && palette_read_strobe_n)
        else $error("palette strobe active before strap capture");
    chk_upper_lane: assert property (!high_byte_buf_en_n |-> !low_byte_buf_en_n)
        else $error("upper lane enabled without an access");
    chk_wide_lane: assert property (!wide_data_select_n |-> !low_byte_buf_en_n)
        else $error("wide select without an access");
    chk_write_lane: assert property ($fell(palette_write_strobe_n) |-> !low_byte_buf_en_n)
        else $error("palette write without lane enable");
    chk_read_lane: assert property (!palette_read_strobe_n |-> !low_byte_buf_en_n)
        else $error("palette read without lane enable");
    chk_strobe_exclusive: assert property (!palette_write_strobe_n |-> palette_read_strobe_n)
        else $error("palette read and write together");
    chk_rom_release: assert property ($fell(bios_rom_select_n) |-> ##[1:20] bios_rom_select_n)
        else $error("ROM select held past the access");

    cover property (!palette_write_strobe_n);
    cover property ($fell(bios_rom_select_n));
    cover property ($rose(memory_cycle_enable));
    cover property (!high_byte_buf_en_n && !wide_data_select_n);
endmodule : hbg_properties

// ==== tb/host_bus_glue_and_strap_test.sv ====
`timescale 1ns/1ns
module host_bus_glue_and_strap_test;
    typedef struct packed {
        logic [1:0]  sel;
        logic [15:0] mask;
        logic [15:0] exp;
    } hbg_note_t;
    logic        clk_in, rst_in, io_rd, io_wr, mem_rd, mem_wr, hi, rom_dec, wide, pull;
    logic        smemr_n, smemw_n, sbhe_n, sa0, siow_n, m_io, made24, latch, dphase, sense;
    logic        rw_n, strap, valid, mce, ug_n, rl_n, rh_n, cx_n, uw_n, subsys;
    logic [15:0] acc_addr, sio_addr, sdata, word;
    logic [8:0]  top;
    logic [4:0]  ahigh;
    logic [2:0]  page;
    hbg_note_t   notes[$];
    hbg_note_t   n;
    int          fail_count, checked, cycles;
    event        ev_sample;
    logic [15:0] addrs[6] = '{16'h03c6, 16'h03c7, 16'h03c8, 16'h03c9, 16'h46e8, 16'h76e8};

    hbg_if bus ();
    hbg_device hbg_device_i (.clk_in(clk_in), .rst_in(rst_in), .bus(bus), .acc_io_rd_in(io_rd),
        .acc_io_wr_in(io_wr), .acc_mem_rd_in(mem_rd), .acc_mem_wr_in(mem_wr),
        .acc_addr_in(acc_addr), .acc_hi_byte_in(hi), .rom_decode_in(rom_dec), .wide_in(wide),
        .bus_arch_strap_out(strap), .strap_valid_out(valid), .host_word_out(word),
        .host_addr_high_out(ahigh), .mem_cycle_en_out(mce));
    hbg_glue hbg_glue_i (.clk_in(clk_in), .rst_in(rst_in), .bus(bus), .strap_pullup_in(pull),
        .smemr_n_in(smemr_n), .smemw_n_in(smemw_n), .sbhe_n_in(sbhe_n), .sa0_in(sa0),
        .siow_n_in(siow_n), .sio_addr_in(sio_addr), .sdata_in(sdata), .saddr_top_in(top),
        .m_io_in(m_io), .made24_in(made24), .addr_latch_in(latch), .data_phase_in(dphase),
        .monitor_sense_in(sense), .rom_is_wide_n_in(rw_n), .upper_buf_gate_n_out(ug_n),
        .rom_low_oe_n_out(rl_n), .rom_high_oe_n_out(rh_n), .rom_cross_buf_gate_n_out(cx_n),
        .upper_buf_gate_wide_rom_n_out(uw_n), .rom_page_addr_out(page),
        .subsys_enable_out(subsys));
    hbg_properties hbg_properties_i (.clk_in(clk_in), .rst_in(rst_in),
        .high_byte_buf_en_n(bus.high_byte_buf_en_n), .low_byte_buf_en_n(bus.low_byte_buf_en_n),
        .bios_rom_select_n(bus.bios_rom_select_n), .wide_data_select_n(bus.wide_data_select_n),
        .palette_write_strobe_n(bus.palette_write_strobe_n),
        .palette_read_strobe_n(bus.palette_read_strobe_n),
        .memory_cycle_enable(bus.memory_cycle_enable));

    // Observed flags, one bit per strobe, gate or status output
    wire logic [15:0] flags = {mce, valid, strap, subsys, bus.memory_cycle_enable, uw_n, cx_n,
        rh_n, rl_n, ug_n, bus.palette_read_strobe_n, bus.palette_write_strobe_n,
        bus.wide_data_select_n, bus.bios_rom_select_n, bus.low_byte_buf_en_n,
        bus.high_byte_buf_en_n};

    // Clock and cycle ceiling
    always #4 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            report_and_stop();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Oldest note against the outputs
    always @(ev_sample) begin
        n = notes.pop_front();
        case (n.sel)
            2'h0: check("flags", flags & n.mask, n.exp & n.mask);
            2'h1: check("host word", word, n.exp);
            default: check("addr page", {8'h00, ahigh, page} & n.mask, n.exp & n.mask);
        endcase
    end

    task automatic step(input int k);
        repeat (k) @(posedge clk_in);
        #1;
    endtask : step

    task automatic expect_out(input logic [1:0] s, input logic [15:0] m, input logic [15:0] e);
        notes.push_back('{s, m, e});
        step(8);
        -> ev_sample;
    endtask : expect_out

    task automatic do_reset(input logic up);
        pull = up;
        rst_in = 1'b1;
        step(10);
        rst_in = 1'b0;
        step(10);
        expect_out(2'h0, 16'h7000, {2'b01, up, 1'b1, 12'h000});
    endtask : do_reset

    task automatic run_random(input logic isa, input int count);
        int   kind;
        logic me, g, acc, pal, setup, e_hi, e_lo, e_rom, e_ds, e_pw, e_pr, ug, rl, rh, cx, uw;
        repeat (count) begin
            kind = $urandom % 5;
            {hi, rom_dec, wide, smemr_n, smemw_n, sbhe_n, sa0, rw_n, m_io, made24} = 10'($urandom);
            top = ($urandom % 2) ? 9'h000 : 9'($urandom);
            acc_addr = addrs[$urandom % 6];
            {io_rd, io_wr, mem_rd, mem_wr} = (kind == 0) ? 4'h0 : 4'(4'h1 << (kind - 1));
            me = !m_io || (top[8:5] == 4'h0 && made24);
            g = isa || me;
            acc = (io_rd || io_wr || mem_rd || mem_wr) && g;
            pal = acc_addr inside {[16'h03c6:16'h03c9]};
            setup = isa && (io_rd || io_wr) && acc_addr[15:14] == 2'b01;
            e_hi = !(acc && (isa || hi));
            e_lo = !acc;
            e_rom = !((rom_dec && mem_rd && g) || setup);
            e_ds = !(acc && wide);
            e_pw = !(io_wr && g && pal);
            e_pr = !(io_rd && g && pal);
            ug = !e_lo && e_rom && !sbhe_n && !e_ds && (!smemw_n || !smemr_n);
            rl = !e_rom && !smemr_n && !sa0;
            rh = !e_rom && !smemr_n && ((!sbhe_n && !rw_n) || (sa0 && rw_n));
            cx = !e_rom && sa0 && !smemr_n && rw_n;
            uw = !sbhe_n && ((!e_lo && !smemw_n && !e_ds) || (!e_rom && !smemr_n && !rw_n)
                || (!e_lo && !smemr_n && !e_ds && e_rom));
            expect_out(2'h0, 16'hffff, {me, 1'b1, isa, 1'b1, me, !uw, !cx, !rh, !rl, !ug,
                e_pr, e_pw, e_ds, e_rom, e_lo, e_hi});
            {io_rd, io_wr, mem_rd, mem_wr} = 4'h0;
            step(2);
        end
        $display("random accesses done, strap %b", isa);
    endtask : run_random

    task automatic write_subsys(input logic v);
        {sio_addr, sdata, siow_n} = {16'h03c3, 15'h0000, v, 1'b0};
        step(4);
        siow_n = 1'b1;
        step(4);
    endtask : write_subsys

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop

    // Main sequence
    initial begin
        {clk_in, rst_in, io_rd, io_wr, mem_rd, mem_wr, hi, rom_dec, wide, latch} = 10'h102;
        {smemr_n, smemw_n, sbhe_n, sa0, siow_n, m_io, made24, dphase, sense, rw_n} = 10'h3f3;
        {acc_addr, sio_addr, sdata, top, pull} = '0;
        void'($urandom(32'hfcaa));
        do_reset(1'b1);
        run_random(1'b1, 40);
        {io_wr, acc_addr, sio_addr, sdata, siow_n} = {1'b1, 16'h56e8, 16'h56e8, 16'h0005, 1'b0};
        step(8);
        {io_wr, siow_n} = 2'b01;
        expect_out(2'h2, 16'h0007, 16'h0005);
        $display("page write done");
        {sdata, dphase} = {16'($urandom), 1'b1};
        expect_out(2'h1, 16'hffff, sdata);
        {sio_addr, sense, dphase} = {16'($urandom), 1'($urandom), 1'b0};
        expect_out(2'h1, 16'hffff, {sense, sio_addr[14:0]});
        {top, latch} = {9'($urandom), 1'b1};
        step(4);
        latch = 1'b0;
        step(1);
        top = ~top;
        expect_out(2'h2, 16'h00f8, {8'h00, ~top[4:0], 3'h0});
        $display("mux and latch done");
        pull = 1'b0;
        expect_out(2'h0, 16'h6000, 16'h6000);
        do_reset(1'b0);
        run_random(1'b0, 40);
        write_subsys(1'b0);
        {io_wr, acc_addr, m_io, hi} = {1'b1, 16'h03c8, 1'b0, 1'b1};
        expect_out(2'h0, 16'h1813, 16'h0013);
        write_subsys(1'b1);
        expect_out(2'h0, 16'h1813, 16'h1800);
        $display("subsystem enable done");
        step(1);
        report_and_stop();
    end
endmodule : host_bus_glue_and_strap_test
